// File: shared/lmr_pkg.sv
// constants and types for the line loss monitor and receive output block
package lmr_pkg;

  // register indices on the command port
  localparam logic [1:0] IDX_STATUS = 2'h0;
  localparam logic [1:0] IDX_DET_CTRL = 2'h2;
  localparam logic [1:0] IDX_RX_CTRL = 2'h3;

  // status register bit positions
  localparam int unsigned ST_LOCK = 4;
  localparam int unsigned ST_LOS = 3;
  localparam int unsigned ST_AMP = 2;
  localparam int unsigned ST_ZERO = 1;
  localparam int unsigned ST_MON = 0;

  // detector control bit positions
  localparam int unsigned DC_AMP_OFF = 2;
  localparam int unsigned DC_ZERO_OFF = 1;
  localparam int unsigned DC_EQ_ON = 0;

  // receive output control bit positions
  localparam int unsigned RC_MUTE = 3;

  // register width and reset values
  localparam int unsigned REG_W = 5;
  localparam logic [4:0] DET_CTRL_RST = 5'h00;
  localparam logic [4:0] RX_CTRL_RST = 5'h00;

  // amplitude declare/clear delay in unit intervals, inside 10..255
  localparam int unsigned AMP_DELAY_UI = 32;
  localparam int unsigned AMP_CNT_W = 8;

  // zero run declare threshold, inside 160 +/- 32
  localparam logic [7:0] ZERO_DECL = 8'ha0;
  // clearance windows: 32 bits, 10 ones, four in a row
  localparam logic [4:0] WIN_LAST = 5'h1f;
  localparam logic [5:0] WIN_ONES_MIN = 6'h0a;
  localparam logic [2:0] WIN_GOOD_LAST = 3'h3;

  // line rate selection
  typedef enum logic [1:0] {
    LMR_MODE_E3 = 2'b00,
    LMR_MODE_DS3 = 2'b01,
    LMR_MODE_STS1 = 2'b10
  } lmr_mode_t;

endpackage

// File: hw/lmr_los_filter.sv
// declare/clear delay filter counted in recovered clock cycles
`timescale 1ns/100ps
`default_nettype none
module lmr_los_filter #(
  parameter int unsigned DELAY = 32,
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw alarm in, filtered alarm out
  input wire logic raw,
  output logic filt_q
);

  logic [W-1:0] cnt_q;
  localparam logic [W-1:0] LAST = W'(DELAY - 1);

  ////////////////////////////////////////////////////////////////////////////
  // count cycles of disagreement, restart on any agreeing cycle
  always_ff @(posedge clk)
  begin
    if (rst || raw == filt_q)
      cnt_q <= '0;
    else if (cnt_q == LAST)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  // flip only after a full delay so a short dropout never toggles
  always_ff @(posedge clk)
  begin
    if (rst)
      filt_q <= 1'b0;
    else if (raw != filt_q && cnt_q == LAST)
      filt_q <= raw; // R1 R2 R19
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm changes exactly after the delay of steady disagreement
  filter_delay_a: assert property ( // R1
    @(posedge clk) disable iff (rst)
    $changed(filt_q) && !$past(rst) |-> $past(cnt_q) == LAST)
    else $error("alarm changed before its delay ran out");

  // a steady raw level never leaves the output behind for long
  filter_bound_a: assert property ( // R2
    @(posedge clk) disable iff (rst)
    (raw != filt_q) [*3] |-> cnt_q != '0 || $changed(filt_q))
    else $error("delay counter stalled while raw disagrees");

endmodule // lmr_los_filter
`default_nettype wire

// File: hw/lmr_line_monitor.sv
// one receive channel: loss supervision, mute and dual-rail output
// Function
// R1: e3 declares loss 10 to 255 UI late
// R2: e3 clears loss 10 to 255 UI after restore
// R3: ds3 alarm is amplitude OR zero-run alarm
// R4: zero-run alarm at 160 consecutive zeros
// R5: clear after four good 32-bit windows
// R6: status amplitude bit mirrors amplitude alarm
// R7: read-only status holds five flags
// R8: detector control bit 2 disables amplitude
// R9: detector control bit 1 disables zero-run
// R10: both disables set means no alarm
// R11: mute forces both rails low on loss
// R12: rails resume after loss clears
// R13: global mute pin mutes all channels
// R14: receive control bit 3 mutes channel
// R15: rails update on recovered clock rise
// R16: clock out runs at line rate
// R17: positive pulse on positive rail, negative likewise
// R18: loss drives alarm pin and status bit
// R19: comparator synchronised, counts per recovered cycle
// R20: framer samples rails on falling edge
`timescale 1ns/100ps
`default_nettype none
module lmr_line_monitor (
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // command port, system clock
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_wdata,
  output logic [4:0] reg_rdata,
  // pins from elsewhere, asynchronous
  input wire logic [1:0] mode_sel,
  input wire logic mute_on_loss_global,
  input wire logic lock_lost_flag,
  input wire logic drive_monitor_flag,
  input wire logic amp_present,
  // recovered line side
  input wire logic rclk,
  input wire logic line_pos,
  input wire logic line_neg,
  // to the receiving terminal
  output logic recovered_clock_out,
  output logic rx_positive_rail,
  output logic rx_negative_rail,
  output logic line_signal_lost,
  output logic equalizer_on
);

  logic [4:0] det_ctrl_q, rx_ctrl_q;
  logic [1:0] lock_sync_q, mon_sync_q, los_sync_q, amp_sync_q, zero_sync_q;
  logic [1:0] rrst_sync_q, mode_s1_q, mode_s2_q, gmute_sync_q, cmute_sync_q;
  logic [1:0] amp_off_sync_q, zero_off_sync_q, amp_in_sync_q;
  logic rrst, amp_off, zero_off, amp_filt, mute_act, one_bit;
  logic amplitude_loss_alarm_q, zero_run_loss_alarm_q, los_q, los_d;
  logic [7:0] zero_cnt_q;
  logic [4:0] bit_cnt_q;
  logic [5:0] ones_cnt_q;
  logic [5:0] ones_total;
  logic [2:0] good_win_q;
  lmr_pkg::lmr_mode_t mode;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: control registers, software writes
  always_ff @(posedge clk)
  begin
    if (rst)
      det_ctrl_q <= lmr_pkg::DET_CTRL_RST;
    else if (reg_wr && reg_addr == lmr_pkg::IDX_DET_CTRL)
      det_ctrl_q <= {2'h0,
        reg_wdata[lmr_pkg::DC_AMP_OFF:lmr_pkg::DC_EQ_ON]}; // R8 R9
  end

  // only the mute bit of the receive control is kept
  always_ff @(posedge clk)
  begin
    if (rst)
      rx_ctrl_q <= lmr_pkg::RX_CTRL_RST;
    else if (reg_wr && reg_addr == lmr_pkg::IDX_RX_CTRL)
    begin
      rx_ctrl_q <= '0;
      rx_ctrl_q[lmr_pkg::RC_MUTE] <= reg_wdata[lmr_pkg::RC_MUTE]; // R14
    end
  end

  // equalizer enable leaves the block as a registered level
  always_ff @(posedge clk)
  begin
    if (rst)
      equalizer_on <= 1'b0;
    else
      equalizer_on <= det_ctrl_q[lmr_pkg::DC_EQ_ON];
  end

  // status flags from the line side and pins, two flops each
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_sync_q <= 2'h0;
      mon_sync_q <= 2'h0;
      los_sync_q <= 2'h0;
      amp_sync_q <= 2'h0;
      zero_sync_q <= 2'h0;
    end
    else
    begin
      lock_sync_q <= {lock_sync_q[0], lock_lost_flag};
      mon_sync_q <= {mon_sync_q[0], drive_monitor_flag};
      los_sync_q <= {los_sync_q[0], los_q};
      amp_sync_q <= {amp_sync_q[0], amplitude_loss_alarm_q};
      zero_sync_q <= {zero_sync_q[0], zero_run_loss_alarm_q};
    end
  end

  // read data: one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 5'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        lmr_pkg::IDX_STATUS:
        begin
          reg_rdata[lmr_pkg::ST_LOCK] <= lock_sync_q[1]; // R7
          reg_rdata[lmr_pkg::ST_LOS] <= los_sync_q[1]; // R18
          reg_rdata[lmr_pkg::ST_AMP] <= amp_sync_q[1]; // R6
          reg_rdata[lmr_pkg::ST_ZERO] <= zero_sync_q[1];
          reg_rdata[lmr_pkg::ST_MON] <= mon_sync_q[1];
        end
        lmr_pkg::IDX_DET_CTRL: reg_rdata <= det_ctrl_q;
        lmr_pkg::IDX_RX_CTRL: reg_rdata <= rx_ctrl_q;
        default: reg_rdata <= 5'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line domain reset, released on the recovered clock
  always_ff @(posedge rclk)
  begin
    rrst_sync_q <= {rrst_sync_q[0], rst};
  end
  assign rrst = rrst_sync_q[1];

  // level crossings into the line domain
  always_ff @(posedge rclk)
  begin
    if (rrst)
    begin
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
      gmute_sync_q <= 2'h0;
      cmute_sync_q <= 2'h0;
      amp_off_sync_q <= 2'h0;
      zero_off_sync_q <= 2'h0;
      amp_in_sync_q <= 2'h3;
    end
    else
    begin
      mode_s1_q <= mode_sel;
      mode_s2_q <= mode_s1_q;
      gmute_sync_q <= {gmute_sync_q[0], mute_on_loss_global}; // R13
      cmute_sync_q <= {cmute_sync_q[0], rx_ctrl_q[lmr_pkg::RC_MUTE]};
      amp_off_sync_q <= {amp_off_sync_q[0],
                         det_ctrl_q[lmr_pkg::DC_AMP_OFF]};
      zero_off_sync_q <= {zero_off_sync_q[0],
                          det_ctrl_q[lmr_pkg::DC_ZERO_OFF]};
      amp_in_sync_q <= {amp_in_sync_q[0], amp_present}; // R19
    end
  end

  // mode bits settle slowly; a code change mid-crossing is harmless
  assign mode = lmr_pkg::lmr_mode_t'(mode_s2_q);
  assign amp_off = amp_off_sync_q[1];
  assign zero_off = zero_off_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // amplitude alarm: comparator hysteresis is analog, delay is here
  lmr_los_filter #(
    .DELAY(lmr_pkg::AMP_DELAY_UI),
    .W(lmr_pkg::AMP_CNT_W)
  ) u_amp_filter (
    .clk(rclk),
    .rst(rrst | amp_off),
    .raw(~amp_in_sync_q[1]),
    .filt_q(amp_filt)
  );

  // disabled detector reports no alarm at once
  always_ff @(posedge rclk)
  begin
    if (rrst)
      amplitude_loss_alarm_q <= 1'b0;
    else
      amplitude_loss_alarm_q <= amp_filt & ~amp_off; // R8 R1 R2
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero run detector: a pulse on either rail is a one
  assign one_bit = line_pos | line_neg;

  // saturating run length of zeros
  always_ff @(posedge rclk)
  begin
    if (rrst || zero_off || one_bit)
      zero_cnt_q <= 8'h00;
    else if (zero_cnt_q != lmr_pkg::ZERO_DECL)
      zero_cnt_q <= zero_cnt_q + 8'h01; // R4
  end

  // window bit position, runs only while the alarm stands
  always_ff @(posedge rclk)
  begin
    if (rrst || !zero_run_loss_alarm_q)
      bit_cnt_q <= 5'h00;
    else
      bit_cnt_q <= bit_cnt_q + 5'h01;
  end

  // ones in the current window, including this cycle
  assign ones_total = ones_cnt_q + {5'h00, one_bit};

  always_ff @(posedge rclk)
  begin
    if (rrst || !zero_run_loss_alarm_q || bit_cnt_q == lmr_pkg::WIN_LAST)
      ones_cnt_q <= 6'h00;
    else
      ones_cnt_q <= ones_total;
  end

  // good windows in a row; one poor window starts over
  always_ff @(posedge rclk)
  begin
    if (rrst || !zero_run_loss_alarm_q)
      good_win_q <= 3'h0;
    else if (bit_cnt_q == lmr_pkg::WIN_LAST)
    begin
      if (ones_total >= lmr_pkg::WIN_ONES_MIN)
        good_win_q <= good_win_q + 3'h1; // R5
      else
        good_win_q <= 3'h0; // R5
    end
  end

  // digital alarm: declare on run, clear on fourth good window
  always_ff @(posedge rclk)
  begin
    if (rrst || zero_off)
      zero_run_loss_alarm_q <= 1'b0; // R9
    else if (!zero_run_loss_alarm_q && !one_bit &&
             zero_cnt_q == lmr_pkg::ZERO_DECL - 8'h01)
      zero_run_loss_alarm_q <= 1'b1; // R4
    else if (zero_run_loss_alarm_q && bit_cnt_q == lmr_pkg::WIN_LAST &&
             ones_total >= lmr_pkg::WIN_ONES_MIN &&
             good_win_q == lmr_pkg::WIN_GOOD_LAST)
      zero_run_loss_alarm_q <= 1'b0; // R5
  end

  ////////////////////////////////////////////////////////////////////////////
  // combined alarm; e3 relies on amplitude only
  always_comb
  begin
    unique case (mode)
      lmr_pkg::LMR_MODE_E3: los_d = amplitude_loss_alarm_q; // R1 R2
      lmr_pkg::LMR_MODE_DS3: los_d = amplitude_loss_alarm_q | zero_run_loss_alarm_q; // R3
      lmr_pkg::LMR_MODE_STS1: los_d = amplitude_loss_alarm_q | zero_run_loss_alarm_q;
      default: los_d = amplitude_loss_alarm_q | zero_run_loss_alarm_q;
    endcase
  end

  // alarm pin is the same flop the status bit samples
  always_ff @(posedge rclk)
  begin
    if (rrst)
      los_q <= 1'b0;
    else
      los_q <= los_d; // R18 R10
  end
  assign line_signal_lost = los_q;

  ////////////////////////////////////////////////////////////////////////////
  // mute on loss when either the pin or the channel bit asks for it
  assign mute_act = los_q & (gmute_sync_q[1] | cmute_sync_q[1]);

  // rails launch on the rising edge so the framer samples at fall
  always_ff @(posedge rclk)
  begin
    if (rrst || mute_act)
    begin
      rx_positive_rail <= 1'b0; // R11
      rx_negative_rail <= 1'b0; // R11
    end
    else
    begin
      rx_positive_rail <= line_pos; // R15 R17 R12 R20
      rx_negative_rail <= line_neg; // R17
    end
  end

  // clock out is the recovered clock itself, never regenerated
  assign recovered_clock_out = rclk; // R16

  ////////////////////////////////////////////////////////////////////////////
  // a freshly declared run always saw the full threshold of zeros
  zero_run_decl_a: assert property ( // R4
    @(posedge rclk) disable iff (rrst)
    $rose(zero_run_loss_alarm_q) |-> $past(zero_cnt_q) == lmr_pkg::ZERO_DECL - 8'h01
      && $past(!one_bit))
    else $error("zero-run alarm set without full run");

  // clearance only after three earlier good windows
  zero_run_clear_a: assert property ( // R5
    @(posedge rclk) disable iff (rrst)
    ($fell(zero_run_loss_alarm_q) && !$past(zero_off)) |->
      $past(good_win_q) == lmr_pkg::WIN_GOOD_LAST &&
      $past(bit_cnt_q) == lmr_pkg::WIN_LAST)
    else $error("zero-run alarm cleared early");

  // ds3 alarm follows the OR of both detectors
  or_alarm_a: assert property ( // R3
    @(posedge rclk) disable iff (rrst)
    (mode == lmr_pkg::LMR_MODE_DS3 && $stable(mode)) |=>
      los_q == $past(amplitude_loss_alarm_q | zero_run_loss_alarm_q))
    else $error("combined alarm is not the OR");

  // amplitude disable silences that alarm next cycle
  amp_disable_a: assert property ( // R8
    @(posedge rclk) disable iff (rrst)
    amp_off |=> !amplitude_loss_alarm_q)
    else $error("amplitude alarm while disabled");

  // both detectors off: no combined alarm after the pipeline
  both_disable_a: assert property ( // R10
    @(posedge rclk) disable iff (rrst)
    (amp_off && zero_off) [*3] |-> !los_q)
    else $error("loss declared with both detectors off");

  // muting holds both rails low
  sequence mute_seen_s;
    mute_act ##1 1'b1;
  endsequence
  mute_rails_a: assert property ( // R11
    @(posedge rclk) disable iff (rrst)
    mute_seen_s |-> !rx_positive_rail && !rx_negative_rail)
    else $error("rail high while muted");

  // unmuted rails carry the received pulses one cycle later
  rail_follow_a: assert property ( // R17
    @(posedge rclk) disable iff (rrst)
    !mute_act |=> rx_positive_rail == $past(line_pos) &&
      rx_negative_rail == $past(line_neg))
    else $error("rail does not follow received pulse");

  // status read returns the synchronised amplitude alarm
  status_amp_a: assert property ( // R6
    @(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == lmr_pkg::IDX_STATUS) |=>
      reg_rdata[lmr_pkg::ST_AMP] == $past(amp_sync_q[1]))
    else $error("status amplitude bit mismatch");

endmodule // lmr_line_monitor
`default_nettype wire

// File: dv/lmr_framer_model.sv
// receiving terminal model: samples both rails opposite the update edge
`timescale 1ns/100ps
`default_nettype none
module lmr_framer_model (
  // recovered clock and rails from the channel
  input wire logic rx_clk,
  input wire logic pos,
  input wire logic neg,
  // last sampled pulse flags
  output logic pos_q,
  output logic neg_q
);
  ////////////////////////////////////////////////////////////////////////
  // falling edge sampling keeps half a cycle of margin both ways
  always @(negedge rx_clk)
  begin
    pos_q <= pos;
    neg_q <= neg;
  end
endmodule // lmr_framer_model
`default_nettype wire

// File: dv/lmr_line_monitor_tb.sv
// self-checking bench for one receive channel
`timescale 1ns/100ps
`default_nettype none
module lmr_line_monitor_tb;
  logic clk, rst, rclk, reg_wr, reg_rd, lock, mon, amp, gmute;
  logic fill, src_p, src_n;
  logic line_pos = 1'b0;
  logic line_neg = 1'b0;
  logic [1:0] reg_addr, mode_sel;
  logic [4:0] reg_wdata, reg_rdata;
  logic rco, rxp, rxn, los, eq, fp, fn;
  int fails, n_checks, hits;

  lmr_line_monitor dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mode_sel(mode_sel), .mute_on_loss_global(gmute),
    .lock_lost_flag(lock), .drive_monitor_flag(mon), .amp_present(amp),
    .rclk(rclk), .line_pos(line_pos), .line_neg(line_neg),
    .recovered_clock_out(rco), .rx_positive_rail(rxp),
    .rx_negative_rail(rxn), .line_signal_lost(los), .equalizer_on(eq)
  );
  lmr_framer_model fr_u (
    .rx_clk(rco), .pos(rxp), .neg(rxn), .pos_q(fp), .neg_q(fn)
  );

  ////////////////////////////////////////////////////////////////////////
  // clocks: system 4 ns, line 48 ns with an odd phase offset
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    rclk = 1'b0;
    #7;
    forever #24 rclk = ~rclk;
  end

  // line source: toggling fill keeps pulse density at one half
  always @(posedge rclk)
  begin
    line_pos <= fill ? ~line_pos : src_p;
    line_neg <= fill ? 1'b0 : src_n;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tally_and_finish;
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task wr(input logic [1:0] a, input logic [4:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read and compare; the idle gap lets crossings settle first
  task rdc(input logic [1:0] a, input logic [4:0] e);
    repeat (12) @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {5'h00, reg_rdata}, {5'h00, e});
  endtask

  // one pulse pair through the channel, seen by the framer
  task send(input logic p, input logic q, input logic mute);
    @(negedge rclk);
    fill = 1'b0;
    src_p = p;
    src_n = q;
    repeat (2) @(posedge rclk);
    @(negedge rclk);
    #1;
    chk("rails", {8'h00, fp, fn}, mute ? 10'h000 : {8'h00, p, q});
    fill = 1'b1;
  endtask

  // line cycles until the alarm reaches level e, bounded
  task wait_los(input logic e, input int lo, input int hi);
    int n;
    n = 0;
    while (los !== e && n < 400)
    begin
      @(posedge rclk);
      #1;
      n++;
    end
    if (n >= 400)
    begin
      chk("los_wait", 10'h000, 10'h001);
      tally_and_finish();
    end
    else
      chk("los_delay", {9'h000, (n >= lo && n <= hi)}, 10'h001);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, lock, amp, fill} = 4'hf;
    {mon, gmute, src_p, src_n} = 4'h0;
    {reg_wr, reg_rd} = 2'h0;
    reg_addr = 2'h0;
    reg_wdata = 5'h00;
    mode_sel = lmr_pkg::LMR_MODE_E3;
    // line side also needs three of its own edges inside reset
    repeat (12) @(posedge clk);
    repeat (3) @(posedge rclk);
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("rst_out", {6'h00, los, rxp, rxn, eq}, 10'h000);
    rdc(lmr_pkg::IDX_STATUS, 5'h10);
    @(posedge clk);
    lock <= 1'b0;
    mon <= 1'b1;
    rdc(lmr_pkg::IDX_STATUS, 5'h01);
    wr(lmr_pkg::IDX_STATUS, 5'h1f);
    rdc(lmr_pkg::IDX_STATUS, 5'h01);
    rdc(lmr_pkg::IDX_DET_CTRL, 5'h00);
    wr(lmr_pkg::IDX_DET_CTRL, 5'h1f);
    rdc(lmr_pkg::IDX_DET_CTRL, 5'h07);
    chk("eq_on", {9'h000, eq}, 10'h001);
    wr(lmr_pkg::IDX_DET_CTRL, 5'h00);
    wr(lmr_pkg::IDX_RX_CTRL, 5'h1f);
    rdc(lmr_pkg::IDX_RX_CTRL, 5'h08);
    send(1'b1, 1'b0, 1'b0);
    send(1'b0, 1'b1, 1'b0);
    send(1'b1, 1'b1, 1'b0);
    chk("clk_out_lo", {9'h000, rco}, 10'h000);
    @(posedge rclk);
    #1;
    chk("clk_out_hi", {9'h000, rco}, 10'h001);
    // amplitude loss in E3 with per-channel mute armed
    @(posedge rclk);
    amp <= 1'b0;
    wait_los(1'b1, 10, 255);
    rdc(lmr_pkg::IDX_STATUS, 5'h0d);
    send(1'b1, 1'b1, 1'b1);
    @(posedge rclk);
    amp <= 1'b1;
    wait_los(1'b0, 10, 255);
    send(1'b1, 1'b1, 1'b0);
    rdc(lmr_pkg::IDX_STATUS, 5'h01);
    // global pin mutes with the channel bit clear
    wr(lmr_pkg::IDX_RX_CTRL, 5'h00);
    gmute <= 1'b1;
    @(posedge rclk);
    amp <= 1'b0;
    wait_los(1'b1, 10, 255);
    send(1'b1, 1'b0, 1'b1);
    @(posedge rclk);
    gmute <= 1'b0;
    repeat (4) @(posedge rclk);
    send(1'b1, 1'b0, 1'b0);
    @(posedge rclk);
    amp <= 1'b1;
    wait_los(1'b0, 10, 255);
    // zero run alone raises the alarm in DS3
    @(posedge rclk);
    mode_sel <= lmr_pkg::LMR_MODE_DS3;
    repeat (4) @(negedge rclk);
    fill = 1'b0;
    src_p = 1'b0;
    src_n = 1'b0;
    wait_los(1'b1, 128, 192);
    fill = 1'b1;
    wait_los(1'b0, 97, 140);
    // both detectors off: no alarm despite no amplitude and no pulses
    wr(lmr_pkg::IDX_DET_CTRL, 5'h06);
    @(posedge rclk);
    amp <= 1'b0;
    fill <= 1'b0;
    hits = 0;
    repeat (300)
    begin
      @(posedge rclk);
      #1;
      if (los !== 1'b0)
        hits++;
    end
    chk("los_off", hits[9:0], 10'h000);
    // zero run in STS-1 with only the amplitude detector off
    @(posedge rclk);
    mode_sel <= lmr_pkg::LMR_MODE_STS1;
    wr(lmr_pkg::IDX_DET_CTRL, 5'h04);
    wait_los(1'b1, 129, 200);
    rdc(lmr_pkg::IDX_STATUS, 5'h0b);
    wr(lmr_pkg::IDX_DET_CTRL, 5'h02);
    repeat (100) @(posedge rclk);
    rdc(lmr_pkg::IDX_STATUS, 5'h0d);
    tally_and_finish();
  end
endmodule // lmr_line_monitor_tb
`default_nettype wire
